/* File: pkg/slt_pkg.sv */
// Shared constants and types for the serial loopback self-test controller
package slt_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_MAX = 19_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_MAX;
  localparam int MEM_DEPTH = 8192;
  localparam int MEM_AW = 13;
  localparam int SETTLE_CYCLES = 8;
  localparam int RX_TIMEOUT_BITS = 30;
  localparam logic [7:0] CHAR_FIRST = 8'h20;
  localparam logic [7:0] CHAR_LAST = 8'h7F;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] MEM_PATTERN = 8'hA5;
  localparam logic [7:0] REV_DIGITS = 8'h10;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h0,
    ST_INIT = 4'h1,
    ST_IDLE = 4'h2,
    ST_PRINT = 4'h3,
    ST_MEM_WR = 4'h4,
    ST_MEM_RD = 4'h5,
    ST_IF_CHK = 4'h6,
    ST_XFER = 4'h7,
    ST_DUMP = 4'h8
  } slt_state_type;

  typedef enum logic [3:0] {
    STEP_LOOP = 4'h0,
    STEP_MEM = 4'h1,
    STEP_IF_LO = 4'h2,
    STEP_IF_HI = 4'h3,
    STEP_XFER = 4'h4,
    STEP_END = 4'h5
  } slt_step_type;

  typedef enum logic [2:0] {
    MSG_REV = 3'h0,
    MSG_LOOP = 3'h1,
    MSG_OK = 3'h2,
    MSG_BAD = 3'h3,
    MSG_IF_OK = 3'h4,
    MSG_IF_BAD = 3'h5
  } slt_msg_type;
endpackage

/* File: logic/slt_buf_ram.sv */
// Single-port message buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module slt_buf_ram #(
  parameter int DEPTH = 8192,
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: logic/slt_loop_test.sv */
// Serial port loopback self-test controller
`timescale 1ns/1ps
`default_nettype none
module slt_loop_test #(
  parameter int BIT_CYCLES = slt_pkg::BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic prn_reset_n,
  input wire logic diag_sel,
  input wire logic plug_fitted,
  input wire logic select_sw,
  input wire logic xon_mode,
  input wire logic rx_data_in,
  input wire logic dsr_in,
  input wire logic cts_in,
  input wire logic cd_in,
  output logic tx_data_out,
  output logic dtr_out,
  output logic rts_out,
  output logic busy_signal_out,
  output logic [7:0] prn_data,
  output logic prn_valid,
  input wire logic prn_ready,
  output logic test_running
);
  localparam int BW = $clog2(BIT_CYCLES + 1);
  localparam int AW = slt_pkg::MEM_AW;

  // Two-flop synchronisers for all input pins except resetn, xon_mode and prn_ready
  logic [7:0] s1_q, s2_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Receive line resets to its idle high level so no false start follows reset
      s1_q <= 8'h08;
      s2_q <= 8'h08;
    end else begin
      s1_q <= {prn_reset_n, diag_sel, plug_fitted, select_sw, rx_data_in, dsr_in, cts_in, cd_in};
      s2_q <= s1_q;
    end
  end
  logic rst_rel, rx_s, sel_s;
  logic [2:0] lines_s;
  assign rst_rel = s2_q[7];
  assign sel_s = s2_q[4];
  assign rx_s = s2_q[3];
  assign lines_s = s2_q[2:0];

  slt_pkg::slt_state_type st_q;
  slt_pkg::slt_step_type step_q;
  slt_pkg::slt_msg_type msg_q;
  logic run_q, sel_d1_q, mode_xon_q, line_lvl_q, fail_q, tx_done_q, dump_ph_q;
  logic [3:0] idx_q;
  logic [AW:0] addr_q;
  logic [7:0] char_q;
  logic [6:0] rx_cnt_q;
  logic [5:0] wait_q;
  logic [7:0] mem_rdata;

  // Print buffer, two entries
  logic [7:0] buf0_q, buf1_q;
  logic [1:0] bcnt_q;
  logic push, pop, in_ready;
  logic [7:0] push_data;
  assign in_ready = (bcnt_q != 2'd2);
  assign prn_valid = (bcnt_q != 2'd0);
  assign prn_data = buf0_q;
  assign pop = prn_valid && prn_ready;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buf0_q <= 8'h00;
      buf1_q <= 8'h00;
      bcnt_q <= 2'd0;
    end else begin
      if (push && !pop) begin
        if (bcnt_q == 2'd0) buf0_q <= push_data;
        else buf1_q <= push_data;
        bcnt_q <= bcnt_q + 2'd1;
      end else if (pop && !push) begin
        buf0_q <= buf1_q;
        bcnt_q <= bcnt_q - 2'd1;
      end else if (push && pop) begin
        if (bcnt_q == 2'd1) begin
          buf0_q <= push_data;
        end else begin
          buf0_q <= buf1_q;
          buf1_q <= push_data;
        end
      end
    end
  end

  // Message text lookup; zero ends a message
  function automatic logic [7:0] msg_byte(input slt_pkg::slt_msg_type m, input logic [3:0] i);
    logic [8*10-1:0] s;
    s = {10{8'h00}};
    unique case (m)
      slt_pkg::MSG_REV: s = {4'h3, slt_pkg::REV_DIGITS[7:4], 4'h3, slt_pkg::REV_DIGITS[3:0], slt_pkg::CHAR_CR, 56'h0};
      slt_pkg::MSG_LOOP: s = {"LOOP TEST", slt_pkg::CHAR_CR};
      slt_pkg::MSG_OK: s = {"OK", slt_pkg::CHAR_CR, 56'h0};
      slt_pkg::MSG_BAD: s = {"BAD", slt_pkg::CHAR_CR, 48'h0};
      slt_pkg::MSG_IF_OK: s = {"IF OK", slt_pkg::CHAR_CR, 32'h0};
      slt_pkg::MSG_IF_BAD: s = {"IF BAD", slt_pkg::CHAR_CR, 24'h0};
      default: s = {10{8'h00}};
    endcase
    if (i > 4'd9) msg_byte = 8'h00;
    else msg_byte = s[8*(9-i) +: 8];
  endfunction

  // Bit-rate divider, one-cycle tick
  logic [BW-1:0] div_q;
  logic bit_tick;
  assign bit_tick = (div_q == BW'(BIT_CYCLES - 1));
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) div_q <= '0;
    else if (st_q == slt_pkg::ST_INIT || bit_tick) div_q <= '0;
    else div_q <= div_q + BW'(1);
  end

  // Transmitter, start-stop framing
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic tx_start, tx_busy;
  logic [7:0] tx_byte;
  assign tx_busy = (tx_bits_q != 4'd0);
  assign tx_data_out = tx_sh_q[0];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh_q <= 10'h3FF;
      tx_bits_q <= 4'd0;
    end else if (tx_start && !tx_busy) begin
      tx_sh_q <= {1'b1, tx_byte, 1'b1};
      tx_bits_q <= 4'd11;
    end else if (tx_busy && bit_tick) begin
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_bits_q <= tx_bits_q - 4'd1;
      if (tx_bits_q == 4'd11) tx_sh_q <= {tx_sh_q[9:1], 1'b0};
    end
  end

  // Receiver runs independently of the transmitter
  logic [BW-1:0] rx_div_q;
  logic [3:0] rx_bits_q;
  logic [7:0] rx_sh_q;
  logic rx_done;
  assign rx_done = (rx_bits_q == 4'd1) && (rx_div_q == '0) && rx_s;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_div_q <= '0;
      rx_bits_q <= 4'd0;
      rx_sh_q <= 8'h00;
    end else if (rx_bits_q == 4'd0) begin
      if (!rx_s) begin
        rx_bits_q <= 4'd10;
        rx_div_q <= BW'(BIT_CYCLES / 2);
      end
    end else if (rx_div_q != '0) begin
      rx_div_q <= rx_div_q - BW'(1);
    end else begin
      rx_div_q <= BW'(BIT_CYCLES - 1);
      rx_bits_q <= rx_bits_q - 4'd1;
      if (rx_bits_q == 4'd10 && rx_s) rx_bits_q <= 4'd0;
      else if (rx_bits_q != 4'd1) rx_sh_q <= {rx_s, rx_sh_q[7:1]};
    end
  end

  // Memory port
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [AW-1:0] mem_addr;
  always_comb begin
    mem_we = 1'b0;
    mem_wdata = rx_sh_q;
    mem_addr = addr_q[AW-1:0];
    if (st_q == slt_pkg::ST_MEM_WR) begin
      mem_we = 1'b1;
      mem_wdata = addr_q[7:0] ^ slt_pkg::MEM_PATTERN;
    end else if (st_q == slt_pkg::ST_XFER) begin
      mem_we = rx_done && (rx_cnt_q < 7'd96);
      mem_addr = AW'(rx_cnt_q);
    end
  end

  slt_buf_ram #(.DEPTH(slt_pkg::MEM_DEPTH), .AW(AW), .DW(8)) u_ram (
    .core_clk(core_clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Print pushes and flow-control characters
  logic [7:0] cur_byte;
  logic xoff_sent_q;
  assign cur_byte = msg_byte(msg_q, idx_q);
  always_comb begin
    push = 1'b0;
    push_data = cur_byte;
    tx_start = 1'b0;
    tx_byte = char_q;
    if (st_q == slt_pkg::ST_PRINT) begin
      push = in_ready && (cur_byte != 8'h00);
    end else if (st_q == slt_pkg::ST_DUMP) begin
      push = in_ready && dump_ph_q;
      push_data = mem_rdata;
    end else if (st_q == slt_pkg::ST_XFER) begin
      tx_start = !tx_done_q;
    end else if (st_q == slt_pkg::ST_IDLE && mode_xon_q) begin
      tx_start = (xoff_sent_q == in_ready);
      tx_byte = in_ready ? slt_pkg::CHAR_XON : slt_pkg::CHAR_XOFF;
    end
  end

  // Select switch toggles the run flag
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_d1_q <= 1'b0;
      run_q <= 1'b0;
      mode_xon_q <= 1'b0;
      xoff_sent_q <= 1'b0;
    end else begin
      sel_d1_q <= sel_s;
      if (!rst_rel) begin
        run_q <= 1'b0;
      end else if (st_q == slt_pkg::ST_INIT) begin
        mode_xon_q <= xon_mode;
        run_q <= s2_q[6] && s2_q[5];
      end else if (st_q != slt_pkg::ST_HOLD && sel_s && !sel_d1_q) begin
        run_q <= !run_q;
      end
      if (st_q == slt_pkg::ST_IDLE && tx_start && !tx_busy) xoff_sent_q <= !in_ready;
    end
  end

  // Test sequencer
  logic [3:0] settle_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= slt_pkg::ST_HOLD;
      step_q <= slt_pkg::STEP_LOOP;
      msg_q <= slt_pkg::MSG_REV;
      idx_q <= 4'd0;
      addr_q <= '0;
      char_q <= slt_pkg::CHAR_FIRST;
      rx_cnt_q <= 7'd0;
      wait_q <= 6'd0;
      line_lvl_q <= 1'b1;
      fail_q <= 1'b0;
      tx_done_q <= 1'b0;
      dump_ph_q <= 1'b0;
      settle_q <= 4'd0;
    end else if (!rst_rel) begin
      st_q <= slt_pkg::ST_HOLD;
    end else if (!run_q && st_q > slt_pkg::ST_IDLE) begin
      st_q <= slt_pkg::ST_IDLE;
      line_lvl_q <= 1'b1;
    end else begin
      unique case (st_q)
        slt_pkg::ST_HOLD: st_q <= slt_pkg::ST_INIT;
        slt_pkg::ST_INIT: st_q <= slt_pkg::ST_IDLE;
        slt_pkg::ST_IDLE: begin
          if (run_q && !tx_busy) begin
            st_q <= slt_pkg::ST_PRINT;
            msg_q <= slt_pkg::MSG_REV;
            step_q <= slt_pkg::STEP_LOOP;
            idx_q <= 4'd0;
          end
        end
        slt_pkg::ST_PRINT: begin
          if (cur_byte == 8'h00) begin
            idx_q <= 4'd0;
            addr_q <= '0;
            unique case (step_q)
              slt_pkg::STEP_LOOP: begin
                msg_q <= slt_pkg::MSG_LOOP;
                step_q <= slt_pkg::STEP_MEM;
              end
              slt_pkg::STEP_MEM: begin
                st_q <= slt_pkg::ST_MEM_WR;
                step_q <= slt_pkg::STEP_IF_LO;
              end
              slt_pkg::STEP_IF_LO, slt_pkg::STEP_IF_HI: begin
                st_q <= slt_pkg::ST_IF_CHK;
                line_lvl_q <= (step_q == slt_pkg::STEP_IF_HI);
                settle_q <= 4'd0;
              end
              slt_pkg::STEP_XFER: begin
                st_q <= slt_pkg::ST_XFER;
                char_q <= slt_pkg::CHAR_FIRST;
                rx_cnt_q <= 7'd0;
                tx_done_q <= 1'b0;
                wait_q <= 6'd0;
              end
              default: st_q <= slt_pkg::ST_IDLE;
            endcase
          end else if (push) begin
            idx_q <= idx_q + 4'd1;
          end
        end
        slt_pkg::ST_MEM_WR: begin
          addr_q <= addr_q + 1'b1;
          if (addr_q[AW-1:0] == AW'(slt_pkg::MEM_DEPTH - 1)) begin
            st_q <= slt_pkg::ST_MEM_RD;
            addr_q <= '0;
            fail_q <= 1'b0;
            dump_ph_q <= 1'b0;
          end
        end
        slt_pkg::ST_MEM_RD: begin
          dump_ph_q <= !dump_ph_q;
          if (dump_ph_q) begin
            if (mem_rdata != (addr_q[7:0] ^ slt_pkg::MEM_PATTERN)) fail_q <= 1'b1;
            addr_q <= addr_q + 1'b1;
            if (addr_q[AW-1:0] == AW'(slt_pkg::MEM_DEPTH - 1)) begin
              st_q <= slt_pkg::ST_PRINT;
              msg_q <= (fail_q || mem_rdata != (addr_q[7:0] ^ slt_pkg::MEM_PATTERN)) ?
                       slt_pkg::MSG_BAD : slt_pkg::MSG_OK;
            end
          end
        end
        slt_pkg::ST_IF_CHK: begin
          settle_q <= settle_q + 4'd1;
          if (settle_q == 4'(slt_pkg::SETTLE_CYCLES)) begin
            st_q <= slt_pkg::ST_PRINT;
            step_q <= line_lvl_q ? slt_pkg::STEP_XFER : slt_pkg::STEP_IF_HI;
            msg_q <= (lines_s == {3{line_lvl_q}}) ? slt_pkg::MSG_IF_OK : slt_pkg::MSG_IF_BAD;
          end
        end
        slt_pkg::ST_XFER: begin
          if (rx_done && rx_cnt_q < 7'd96) rx_cnt_q <= rx_cnt_q + 7'd1;
          if (tx_start && !tx_busy) begin
            if (char_q == slt_pkg::CHAR_LAST) tx_done_q <= 1'b1;
            else char_q <= char_q + 8'd1;
          end
          if (tx_done_q && !tx_busy && bit_tick) wait_q <= wait_q + 6'd1;
          if (tx_done_q && (rx_cnt_q == 7'd96 || wait_q == 6'(slt_pkg::RX_TIMEOUT_BITS))) begin
            st_q <= slt_pkg::ST_DUMP;
            addr_q <= '0;
            dump_ph_q <= 1'b0;
          end
        end
        slt_pkg::ST_DUMP: begin
          if (addr_q == (AW+1)'(rx_cnt_q)) begin
            st_q <= slt_pkg::ST_PRINT;
            step_q <= slt_pkg::STEP_END;
            msg_q <= slt_pkg::MSG_REV;
            idx_q <= 4'd10;
          end else if (!dump_ph_q) begin
            dump_ph_q <= 1'b1;
          end else if (push) begin
            dump_ph_q <= 1'b0;
            addr_q <= addr_q + 1'b1;
          end
        end
        default: st_q <= slt_pkg::ST_HOLD;
      endcase
    end
  end

  // Line outputs
  logic hold_lines;
  assign hold_lines = (st_q == slt_pkg::ST_HOLD || st_q == slt_pkg::ST_INIT);
  assign dtr_out = hold_lines ? 1'b0 : line_lvl_q;
  assign rts_out = hold_lines ? 1'b0 : line_lvl_q;
  assign busy_signal_out = (st_q == slt_pkg::ST_IDLE) ? (mode_xon_q || in_ready) : (!hold_lines && line_lvl_q);
  assign test_running = run_q;
endmodule
`default_nettype wire

/* File: verification/slt_plug_model.sv */
// Loopback plug model tying each output line back to an input
`timescale 1ns/1ps
`default_nettype none
module slt_plug_model (
  input wire logic tx_data_out,
  input wire logic dtr_out,
  input wire logic rts_out,
  input wire logic busy_signal_out,
  input wire logic fault,
  output logic rx_data_in,
  output logic dsr_in,
  output logic cts_in,
  output logic cd_in
);
  assign rx_data_in = tx_data_out;
  assign cts_in = rts_out;
  assign cd_in = busy_signal_out;
  // Fault knob inverts one return line so both line checks must fail
  assign dsr_in = fault ? ~dtr_out : dtr_out;
endmodule
`default_nettype wire

/* File: verification/slt_loop_test_assertions.sv */
// Assertion checker for the loopback self-test controller ports
`timescale 1ns/1ps
`default_nettype none
module slt_loop_test_checker #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic prn_reset_n,
  input wire logic diag_sel,
  input wire logic plug_fitted,
  input wire logic select_sw,
  input wire logic xon_mode,
  input wire logic rx_data_in,
  input wire logic dsr_in,
  input wire logic cts_in,
  input wire logic cd_in,
  input wire logic tx_data_out,
  input wire logic dtr_out,
  input wire logic rts_out,
  input wire logic busy_signal_out,
  input wire logic [7:0] prn_data,
  input wire logic prn_valid,
  input wire logic prn_ready,
  input wire logic test_running
);
  logic tx_prev_q;
  logic run_ok_q;
  int run_len_q;
  // Cycles since the transmit line last changed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_prev_q <= 1'b1;
      run_ok_q <= 1'b0;
      run_len_q <= 0;
    end else begin
      tx_prev_q <= tx_data_out;
      run_ok_q <= test_running & (run_ok_q | (tx_data_out != tx_prev_q));
      run_len_q <= (tx_data_out != tx_prev_q) ? 1 : run_len_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_hold_quiet;
    !prn_reset_n [*4] |-> !test_running && !dtr_out && !rts_out;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("activity while printer reset held");
  property p_reset_exit;
    $rose(resetn) |-> tx_data_out && !dtr_out && !prn_valid && !test_running;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("outputs wrong after reset");
  property p_start;
    $rose(select_sw) && !test_running && prn_reset_n && $past(prn_reset_n, 8) |-> ##[1:8] test_running;
  endproperty
  a_start: assert property (p_start) else $error("press did not start test");
  property p_stop;
    $rose(select_sw) && test_running |-> ##[1:8] !test_running;
  endproperty
  a_stop: assert property (p_stop) else $error("press did not stop test");
  property p_lines_pair;
    dtr_out == rts_out;
  endproperty
  a_lines_pair: assert property (p_lines_pair) else $error("control lines differ");
  property p_busy_level;
    test_running && $past(test_running) && (!dtr_out || !prn_valid) |-> busy_signal_out == dtr_out;
  endproperty
  a_busy_level: assert property (p_busy_level) else $error("busy line off test level");
  property p_settle_low;
    $fell(dtr_out) && test_running |-> !dtr_out [*8];
  endproperty
  a_settle_low: assert property (p_settle_low) else $error("low level too short");
  property p_settle_high;
    $rose(dtr_out) && test_running |-> dtr_out [*8];
  endproperty
  a_settle_high: assert property (p_settle_high) else $error("high level too short");
  property p_start_bit;
    $fell(tx_data_out) |-> !tx_data_out [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
  property p_bit_time;
    (tx_data_out != tx_prev_q) && run_ok_q && test_running |-> (run_len_q % BIT_CYCLES) == 0;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit edge off tick");
  property p_hold_data;
    prn_valid && !prn_ready |=> prn_valid && $stable(prn_data);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("printer byte dropped");
  c_start: cover property ($rose(test_running));
  c_take: cover property (prn_valid && prn_ready);
  c_low: cover property ($fell(dtr_out) && test_running);
  c_frame: cover property ($fell(tx_data_out));
endmodule
bind slt_loop_test slt_loop_test_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .prn_reset_n(prn_reset_n), .diag_sel(diag_sel),
  .plug_fitted(plug_fitted), .select_sw(select_sw), .xon_mode(xon_mode), .rx_data_in(rx_data_in),
  .dsr_in(dsr_in), .cts_in(cts_in), .cd_in(cd_in), .tx_data_out(tx_data_out), .dtr_out(dtr_out),
  .rts_out(rts_out), .busy_signal_out(busy_signal_out), .prn_data(prn_data), .prn_valid(prn_valid),
  .prn_ready(prn_ready), .test_running(test_running));
`default_nettype wire

/* File: verification/test_serial_port_loopback_self_test.sv */
// Self-checking bench for the loopback self-test controller
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_loopback_self_test;
  localparam int BITS = 16;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic prn_reset_n = 1'b0;
  logic diag_sel = 1'b0;
  logic plug_fitted = 1'b1;
  logic select_sw = 1'b0;
  logic xon_mode = 1'b0;
  logic prn_ready = 1'b0;
  logic fault = 1'b1;
  logic stall = 1'b0;
  int wt;
  logic rx_data_in, dsr_in, cts_in, cd_in, tx_data_out, dtr_out, rts_out, busy_signal_out;
  logic prn_valid, test_running;
  logic [7:0] prn_data;
  logic [31:0] rnd = 32'h2;
  logic [7:0] exp_q[$];
  int checks = 0;
  int bad_count = 0;
  always #2.5 core_clk = ~core_clk;
  slt_loop_test #(.BIT_CYCLES(BITS)) dut (.core_clk(core_clk), .resetn(resetn), .prn_reset_n(prn_reset_n),
    .diag_sel(diag_sel), .plug_fitted(plug_fitted), .select_sw(select_sw), .xon_mode(xon_mode),
    .rx_data_in(rx_data_in), .dsr_in(dsr_in), .cts_in(cts_in), .cd_in(cd_in), .tx_data_out(tx_data_out),
    .dtr_out(dtr_out), .rts_out(rts_out), .busy_signal_out(busy_signal_out), .prn_data(prn_data),
    .prn_valid(prn_valid), .prn_ready(prn_ready), .test_running(test_running));
  slt_plug_model plug (.tx_data_out(tx_data_out), .dtr_out(dtr_out), .rts_out(rts_out),
    .busy_signal_out(busy_signal_out), .fault(fault), .rx_data_in(rx_data_in), .dsr_in(dsr_in),
    .cts_in(cts_in), .cd_in(cd_in));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic push_line(input string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
    exp_q.push_back(slt_pkg::CHAR_CR);
  endtask
  // Expected printout of one pass up to the line checks
  task automatic push_head(input logic lo_bad, input logic hi_bad, input logic full);
    exp_q.push_back(8'h30 + (slt_pkg::REV_DIGITS >> 4));
    exp_q.push_back(8'h30 + (slt_pkg::REV_DIGITS & 8'h0F));
    exp_q.push_back(slt_pkg::CHAR_CR);
    push_line("LOOP TEST");
    if (full) begin
      push_line("OK");
      if (lo_bad) push_line("IF BAD");
      else push_line("IF OK");
      if (hi_bad) push_line("IF BAD");
      else push_line("IF OK");
    end
  endtask
  task automatic press;
    select_sw <= 1'b1;
    repeat (6) @(posedge core_clk);
    select_sw <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic wait_empty(input int lim);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      bad_count++;
      test_done;
    end
  endtask
  // Printer side with random stalls; compares every byte taken
  always @(posedge core_clk) begin
    rnd <= xs(rnd);
    prn_ready <= !stall && (rnd[1:0] != 2'h0);
    if (resetn && prn_valid === 1'b1 && prn_ready) begin
      if (exp_q.size() == 0) check("extra byte", 8'h01, 8'h00);
      else check("printed byte", prn_data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("running in hold", {7'h0, test_running}, 8'h00);
    check("dtr in hold", {7'h0, dtr_out}, 8'h00);
    prn_reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    check("running without diag", {7'h0, test_running}, 8'h00);
    push_head(1'b1, 1'b1, 1'b1);
    for (int c = slt_pkg::CHAR_FIRST; c <= slt_pkg::CHAR_LAST; c++) exp_q.push_back(8'(c));
    press;
    check("running after press", {7'h0, test_running}, 8'h01);
    wait_empty(60000);
    fault <= 1'b0;
    push_head(1'b0, 1'b0, 1'b1);
    wait_empty(40000);
    press;
    check("running after stop", {7'h0, test_running}, 8'h00);
    check("dtr idle", {7'h0, dtr_out}, 8'h01);
    // An aborted frame still runs to its stop bit
    repeat (200) @(posedge core_clk);
    check("tx idle", {7'h0, tx_data_out}, 8'h01);
    resetn <= 1'b0;
    diag_sel <= 1'b1;
    xon_mode <= 1'b1;
    stall <= 1'b1;
    // Stalled printer fills the buffer with the two digits before the stop
    exp_q.push_back(8'h30 + (slt_pkg::REV_DIGITS >> 4));
    exp_q.push_back(8'h30 + (slt_pkg::REV_DIGITS & 8'h0F));
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge core_clk);
    check("auto start", {7'h0, test_running}, 8'h01);
    press;
    check("running after flow stop", {7'h0, test_running}, 8'h00);
    check("busy in flow mode", {7'h0, busy_signal_out}, 8'h01);
    wt = 0;
    while (tx_data_out === 1'b1 && wt < 40) begin
      @(posedge core_clk);
      wt++;
    end
    check("flow char start bit", {7'h0, tx_data_out}, 8'h00);
    stall <= 1'b0;
    wait_empty(2000);
    test_done;
  end
endmodule
`default_nettype wire
